// ===== verilog/bps_defines.svh
// offsets, field positions, reset values and timing figures of the supervisor
// assumes an 8 ns bus clock; included by the package and the design
`ifndef BPS_DEFINES_SVH
`define BPS_DEFINES_SVH

`define OFS_CTRL        8'h00
`define OFS_SHORT_CFG   8'h04
`define OFS_TRIP_LEVEL  8'h08
`define OFS_TRIP_DELAY  8'h0c
`define OFS_RETRY_LIMIT 8'h10
`define OFS_RETRY_IVAL  8'h14
`define OFS_OUT_CFG     8'h18
`define OFS_VOLT_LIM    8'h1c
`define OFS_TEMP_LIM    8'h20
`define OFS_STATUS      8'h24
`define OFS_OUT_QUERY   8'h28
`define OFS_SOC_QUERY   8'h2c
`define OFS_FLAG_QUERY  8'h30
`define OFS_STATE_QUERY 8'h34

`define CTRL_SW_PACK    0
`define CTRL_SW_LOAD    1
`define CTRL_SW_CHG     2
`define CTRL_SW_BRAKE   3
`define CTRL_AUTO       4
`define CTRL_CLEAR      5
`define CTRL_SCRIPT     6
`define CTRL_BAL_EN     7

`define OUT_POL0        4
`define OUT_MAN0        6

`define CTRL_RST        32'h0000_001f
`define SHORT_RST       32'h0000_0000
`define LEVEL_RST       32'h0064_0064
`define DELAY_RST       32'h01f4_01f4
`define LIMIT_RST       32'h0000_0000
`define IVAL_RST        32'h03e8_03e8
`define OUT_RST         32'h0000_0030
`define VOLT_RST        32'h0bb8_1068
`define TEMP_RST        32'h0005_003c

`define CLK_NS          8
`define MS_NS           1000000
`define SHORT_QUICK_NS  1000
`define SHORT_MED_NS    10000
`define SHORT_SLOW_NS   100000
`define PULSE_STEP_NS   32
`define SYNC_STEPS      9'h101

`endif

// ===== verilog/bps_pkg.sv
// types shared by the supervisor and its bench
// relies on bps_defines.svh for all figures
package bps_pkg;
  `include "bps_defines.svh"

  typedef enum logic [1:0]
  {
    CH_CONNECTED = 2'b00,
    CH_RETRY     = 2'b01,
    CH_LOCKED    = 2'b11
  } chan_state_e;

  typedef enum logic [1:0]
  {
    TRIG_NEVER = 2'h0,
    TRIG_TEMP  = 2'h1,
    TRIG_VOLT  = 2'h2,
    TRIG_LOAD  = 2'h3
  } out_trig_e;

  typedef enum logic [1:0]
  {
    RESP_QUICK  = 2'h0,
    RESP_MEDIUM = 2'h1,
    RESP_SLOW   = 2'h2,
    RESP_OFF    = 2'h3
  } short_resp_e;

  typedef struct packed
  {
    logic [15:0] load_amps;
    logic [15:0] charge_amps;
    logic [1:0]  short_seen;
    logic [15:0] max_cell_mv;
    logic [15:0] min_cell_mv;
    logic [7:0]  board_temp;
    logic [23:0] ext_temp;
    logic [2:0]  ext_valid;
    logic [7:0]  soc;
  } meas_s;

  typedef struct packed
  {
    logic balancing_active;
    logic health_error_flag;
    logic internal_fault;
    logic cell_wiring_missing;
    logic hard_fault;
    logic regenerating_state;
  } cond_s;
endpackage

// ===== verilog/battery_protection_supervisor.sv
// protection, switch control, output triggers and status reporting
// measurements arrive synchronous to pclk; registers over an apb slave
//
// Function
// [RULE_01] four independent path switches
// [RULE_02] auto trip by default, manual switch control
// [RULE_03] per-channel short response, 3 disables
// [RULE_04] overcurrent trips after level held delay
// [RULE_05] after trip lock or bounded timed retries
// [RULE_06] voltage and temperature limits open paths
// [RULE_07] periodic board temp, up to three externals
// [RULE_08] general outputs never forced off by faults
// [RULE_09] per-output trigger select never/temp/volt/load
// [RULE_10] never trigger leaves output to software
// [RULE_11] defaults active high and never trigger
// [RULE_12] active level while condition holds
// [RULE_13] over-temp clears below limit minus hysteresis
// [RULE_14] outputs are low-side switches to pack negative
// [RULE_15] output readback query returns both outputs
// [RULE_16] status-flag byte layout
// [RULE_17] system-state byte layout
// [RULE_18] continuous pulse train of three values
// [RULE_19] three queries: charge, flags, state
// [RULE_20] zero retries latches off, sets safe lock
// [RULE_21] both bytes updated coherently
`timescale 1ns/1ps
`default_nettype none
`include "bps_defines.svh"

module battery_protection_supervisor
#(
  parameter int NUM_EXT_TEMP = 3,
  parameter int MS_CYC       = `MS_NS / `CLK_NS,
  parameter int SHORT_Q_CYC  = (`SHORT_QUICK_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int SHORT_M_CYC  = (`SHORT_MED_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int SHORT_S_CYC  = (`SHORT_SLOW_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int TEMP_CYC     = `MS_NS / `CLK_NS,
  parameter int STEP_CYC     = (`PULSE_STEP_NS + `CLK_NS - 1) / `CLK_NS
)
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output var  logic [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire bps_pkg::meas_s  meas,
  input  wire bps_pkg::cond_s  cond,
  output var  logic            pack_switch_on,
  output var  logic            load_switch_on,
  output var  logic            charge_switch_on,
  output var  logic            brake_switch_on,
  output var  logic            general_output_one,
  output var  logic            general_output_two,
  output var  logic            pulse_train_report
);
  import bps_pkg::*;

  logic [31:0] ctrl_ff, short_ff, level_ff, delay_ff, limit_ff, ival_ff;
  logic [31:0] outcfg_ff, volt_ff, temp_ff;
  logic        rd_setup, wr_access, fault_clear;
  logic [31:0] nxt_rdata;
  logic        addr_ok;

  chan_state_e chan_ff   [2];
  logic [15:0] oc_ms_ff  [2];
  logic [19:0] sc_cnt_ff [2];
  logic [15:0] wait_ms_ff[2];
  logic [7:0]  tries_ff  [2];
  logic [1:0]  over_amps, oc_trip, sc_trip, trip;
  logic [1:0]  oc_seen_ff, sc_seen_ff;
  logic [19:0] ms_cnt_ff;
  logic        ms_tick;

  logic [7:0]  board_temp_ff;
  logic [19:0] temp_cnt_ff;
  logic [7:0]  max_temp, min_temp;
  logic        ot_ff, ut_flag, ov_flag, uv_flag, auto_on;
  logic [1:0]  gpo_active;
  logic [7:0]  flag_byte, state_byte;

  logic [1:0]  pt_slot_ff;
  logic [8:0]  pt_step_ff;
  logic [19:0] pt_cyc_ff;
  logic [8:0]  pt_high;

  function automatic logic [19:0] short_cycles(input logic [1:0] resp);
    unique case (resp)
      RESP_QUICK:  short_cycles = SHORT_Q_CYC[19:0];
      RESP_MEDIUM: short_cycles = SHORT_M_CYC[19:0];
      default:     short_cycles = SHORT_S_CYC[19:0];
    endcase
  endfunction

  function automatic logic [15:0] half(input logic [31:0] w, input int c);
    half = (c == 0) ? w[15:0] : w[31:16];
  endfunction

  // apb slave: zero wait states, read data captured in setup
  assign rd_setup    = psel && !penable && !pwrite;
  assign wr_access   = psel && penable && pwrite && addr_ok;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !addr_ok;
  assign addr_ok     = (paddr[1:0] == 2'b00) && (paddr <= `OFS_STATE_QUERY);
  assign fault_clear = wr_access && (paddr == `OFS_CTRL) && pwdata[`CTRL_CLEAR];
  assign auto_on     = ctrl_ff[`CTRL_AUTO];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff   <= `CTRL_RST;
      short_ff  <= `SHORT_RST;
      level_ff  <= `LEVEL_RST;
      delay_ff  <= `DELAY_RST;
      limit_ff  <= `LIMIT_RST;
      ival_ff   <= `IVAL_RST;
      outcfg_ff <= `OUT_RST;
      volt_ff   <= `VOLT_RST;
      temp_ff   <= `TEMP_RST;
    end
    else if (wr_access)
    begin
      unique case (paddr)
        // clear bit is a strobe and never stored
        `OFS_CTRL:        ctrl_ff   <= pwdata & ~(32'h1 << `CTRL_CLEAR);
        `OFS_SHORT_CFG:   short_ff  <= {28'h0, pwdata[3:0]};
        `OFS_TRIP_LEVEL:  level_ff  <= pwdata;
        `OFS_TRIP_DELAY:  delay_ff  <= pwdata;
        `OFS_RETRY_LIMIT: limit_ff  <= {16'h0, pwdata[15:0]};
        `OFS_RETRY_IVAL:  ival_ff   <= pwdata;
        `OFS_OUT_CFG:     outcfg_ff <= {24'h0, pwdata[7:0]};
        `OFS_VOLT_LIM:    volt_ff   <= pwdata;
        `OFS_TEMP_LIM:    temp_ff   <= {8'h0, pwdata[23:0]};
        default:          ;
      endcase
    end
  end

  always_comb
  begin
    nxt_rdata = 32'h0;
    unique case (paddr)
      `OFS_CTRL:        nxt_rdata = ctrl_ff;
      `OFS_SHORT_CFG:   nxt_rdata = short_ff;
      `OFS_TRIP_LEVEL:  nxt_rdata = level_ff;
      `OFS_TRIP_DELAY:  nxt_rdata = delay_ff;
      `OFS_RETRY_LIMIT: nxt_rdata = limit_ff;
      `OFS_RETRY_IVAL:  nxt_rdata = ival_ff;
      `OFS_OUT_CFG:     nxt_rdata = outcfg_ff;
      `OFS_VOLT_LIM:    nxt_rdata = volt_ff;
      `OFS_TEMP_LIM:    nxt_rdata = temp_ff;
      `OFS_STATUS:      nxt_rdata = {2'h0, general_output_two, general_output_one,
                                     brake_switch_on, charge_switch_on,
                                     load_switch_on, pack_switch_on,
                                     meas.soc, state_byte, flag_byte};
      // [RULE_15] output readback
      `OFS_OUT_QUERY:   nxt_rdata = {30'h0, general_output_two, general_output_one};
      // [RULE_19] three queries
      `OFS_SOC_QUERY:   nxt_rdata = {24'h0, meas.soc};
      `OFS_FLAG_QUERY:  nxt_rdata = {24'h0, flag_byte};
      `OFS_STATE_QUERY: nxt_rdata = {24'h0, state_byte};
      default:          nxt_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (rd_setup)
      prdata <= nxt_rdata;
  end

  // millisecond base for trip and retry timers
  assign ms_tick = (ms_cnt_ff == 20'(MS_CYC - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ms_cnt_ff <= 20'h0;
    else
      ms_cnt_ff <= ms_tick ? 20'h0 : ms_cnt_ff + 20'h1;
  end

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      over_amps[c] = ((c == 0) ? meas.load_amps : meas.charge_amps) > half(level_ff, c);
      // [RULE_04] level held for the delay
      oc_trip[c]   = over_amps[c] && (oc_ms_ff[c] >= half(delay_ff, c));
      // [RULE_03] response select, off never trips
      sc_trip[c]   = meas.short_seen[c] && (short_ff[2*c +: 2] != RESP_OFF)
                     && (sc_cnt_ff[c] >= short_cycles(short_ff[2*c +: 2]));
      trip[c]      = auto_on && (chan_ff[c] == CH_CONNECTED) && (oc_trip[c] || sc_trip[c]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int c = 0; c < 2; c++)
      begin
        chan_ff[c]    <= CH_CONNECTED;
        oc_ms_ff[c]   <= 16'h0;
        sc_cnt_ff[c]  <= 20'h0;
        wait_ms_ff[c] <= 16'h0;
        tries_ff[c]   <= 8'h0;
      end
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (chan_ff[c] != CH_CONNECTED || !over_amps[c])
          oc_ms_ff[c] <= 16'h0;
        else if (ms_tick && oc_ms_ff[c] != 16'hffff)
          oc_ms_ff[c] <= oc_ms_ff[c] + 16'h1;
        if (chan_ff[c] != CH_CONNECTED || !meas.short_seen[c])
          sc_cnt_ff[c] <= 20'h0;
        else if (sc_cnt_ff[c] != 20'hfffff)
          sc_cnt_ff[c] <= sc_cnt_ff[c] + 20'h1;
        unique case (chan_ff[c])
          CH_CONNECTED:
          begin
            wait_ms_ff[c] <= 16'h0;
            // [RULE_05] retry while budget remains
            // [RULE_20] zero budget latches off
            if (trip[c])
              chan_ff[c] <= (tries_ff[c] < limit_ff[8*c +: 8]) ? CH_RETRY : CH_LOCKED;
          end
          CH_RETRY:
          begin
            if (wait_ms_ff[c] >= half(ival_ff, c))
            begin
              chan_ff[c]  <= CH_CONNECTED;
              tries_ff[c] <= tries_ff[c] + 8'h1;
            end
            else if (ms_tick)
              wait_ms_ff[c] <= wait_ms_ff[c] + 16'h1;
          end
          CH_LOCKED:
          begin
            if (fault_clear)
            begin
              chan_ff[c]  <= CH_CONNECTED;
              tries_ff[c] <= 8'h0;
            end
          end
          default: chan_ff[c] <= CH_LOCKED;
        endcase
      end
    end
  end

  // trip causes are sticky; a trip in the clear cycle survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oc_seen_ff <= 2'b00;
      sc_seen_ff <= 2'b00;
    end
    else
    begin
      oc_seen_ff <= (fault_clear ? 2'b00 : oc_seen_ff) | (trip & oc_trip);
      sc_seen_ff <= (fault_clear ? 2'b00 : sc_seen_ff) | (trip & sc_trip);
    end
  end

  // [RULE_07] periodic board sample
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      temp_cnt_ff   <= 20'h0;
      board_temp_ff <= 8'h0;
    end
    else if (temp_cnt_ff == 20'(TEMP_CYC - 1))
    begin
      temp_cnt_ff   <= 20'h0;
      board_temp_ff <= meas.board_temp;
    end
    else
      temp_cnt_ff <= temp_cnt_ff + 20'h1;
  end

  always_comb
  begin
    max_temp = board_temp_ff;
    min_temp = board_temp_ff;
    for (int s = 0; s < NUM_EXT_TEMP && s < 3; s++)
    begin
      if (meas.ext_valid[s] && meas.ext_temp[8*s +: 8] > max_temp)
        max_temp = meas.ext_temp[8*s +: 8];
      if (meas.ext_valid[s] && meas.ext_temp[8*s +: 8] < min_temp)
        min_temp = meas.ext_temp[8*s +: 8];
    end
  end

  // [RULE_06] limit checks
  assign ov_flag = meas.max_cell_mv > volt_ff[15:0];
  assign uv_flag = meas.min_cell_mv < volt_ff[31:16];
  assign ut_flag = min_temp < temp_ff[15:8];

  // [RULE_13] clear below limit minus hysteresis
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ot_ff <= 1'b0;
    else if (max_temp > temp_ff[7:0])
      ot_ff <= 1'b1;
    else if ({1'b0, max_temp} + {1'b0, temp_ff[23:16]} < {1'b0, temp_ff[7:0]})
      ot_ff <= 1'b0;
  end

  // [RULE_01] independent switches
  // [RULE_02] auto protection gates manual pack, load and charge requests; brake is only forced on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pack_switch_on   <= 1'b0;
      load_switch_on   <= 1'b0;
      charge_switch_on <= 1'b0;
      brake_switch_on  <= 1'b0;
    end
    else
    begin
      pack_switch_on   <= ctrl_ff[`CTRL_SW_PACK] && !(auto_on && (ot_ff || ut_flag));
      load_switch_on   <= ctrl_ff[`CTRL_SW_LOAD] && chan_ff[0] == CH_CONNECTED
                          && !(auto_on && (uv_flag || ot_ff || ut_flag));
      charge_switch_on <= ctrl_ff[`CTRL_SW_CHG] && chan_ff[1] == CH_CONNECTED
                          && !(auto_on && (ov_flag || ot_ff || ut_flag));
      // regenerated energy goes to the resistor when cells are full
      brake_switch_on  <= ctrl_ff[`CTRL_SW_BRAKE]
                          || (auto_on && ov_flag && cond.regenerating_state);
    end
  end

  // [RULE_09] trigger select
  // [RULE_10] never follows the software bit
  // [RULE_08] no fault gating on these outputs
  always_comb
  begin
    for (int k = 0; k < 2; k++)
    begin
      unique case (out_trig_e'(outcfg_ff[2*k +: 2]))
        TRIG_NEVER: gpo_active[k] = outcfg_ff[`OUT_MAN0 + k];
        TRIG_TEMP:  gpo_active[k] = ot_ff;
        TRIG_VOLT:  gpo_active[k] = ov_flag;
        TRIG_LOAD:  gpo_active[k] = |oc_seen_ff || |sc_seen_ff;
      endcase
    end
  end

  // [RULE_11] polarity picks the active level
  // [RULE_12] level follows the condition
  // [RULE_14] high turns the low-side switch on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      general_output_one <= 1'b0;
      general_output_two <= 1'b0;
    end
    else
    begin
      general_output_one <= outcfg_ff[`OUT_POL0] ? gpo_active[0] : !gpo_active[0];
      general_output_two <= outcfg_ff[`OUT_POL0 + 1] ? gpo_active[1] : !gpo_active[1];
    end
  end

  // [RULE_16] flag byte
  // [RULE_21] built from current state, no extra stage
  assign flag_byte = {ctrl_ff[`CTRL_SCRIPT], cond.balancing_active,
                      cond.health_error_flag, cond.internal_fault,
                      uv_flag, ov_flag, |sc_seen_ff, |oc_seen_ff};
  // [RULE_17] state byte
  assign state_byte = {1'b0, cond.cell_wiring_missing, cond.hard_fault,
                       chan_ff[0] == CH_LOCKED || chan_ff[1] == CH_LOCKED,
                       cond.regenerating_state, load_switch_on,
                       ctrl_ff[`CTRL_BAL_EN], charge_switch_on};

  // [RULE_18] sync pulse, then charge, flags, state; high for value+1 steps
  always_comb
  begin
    unique case (pt_slot_ff)
      2'd0:    pt_high = `SYNC_STEPS;
      2'd1:    pt_high = {1'b0, meas.soc} + 9'h1;
      2'd2:    pt_high = {1'b0, flag_byte} + 9'h1;
      default: pt_high = {1'b0, state_byte} + 9'h1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pt_cyc_ff          <= 20'h0;
      pt_step_ff         <= 9'h0;
      pt_slot_ff         <= 2'd0;
      pulse_train_report <= 1'b0;
    end
    else
    begin
      pulse_train_report <= pt_step_ff < pt_high;
      if (pt_cyc_ff == 20'(STEP_CYC - 1))
      begin
        pt_cyc_ff <= 20'h0;
        if (pt_step_ff == `SYNC_STEPS + 9'h1)
        begin
          pt_step_ff <= 9'h0;
          pt_slot_ff <= pt_slot_ff + 2'd1;
        end
        else
          pt_step_ff <= pt_step_ff + 9'h1;
      end
      else
        pt_cyc_ff <= pt_cyc_ff + 20'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_zero_retry_lock;
    trip[0] && limit_ff[7:0] == 8'h0 |=> chan_ff[0] == CH_LOCKED ##1 state_byte[4];
  endproperty
  a_zero_retry_lock: assert property (p_zero_retry_lock) else $error("no lock"); // [RULE_20]

  property p_retry_bound;
    tries_ff[0] <= limit_ff[7:0] || $past(fault_clear) || $changed(limit_ff);
  endproperty
  a_retry_bound: assert property (p_retry_bound) else $error("too many retries"); // [RULE_05]

  property p_short_off;
    short_ff[1:0] == RESP_OFF && !oc_trip[0] |-> !trip[0];
  endproperty
  a_short_off: assert property (p_short_off) else $error("disabled short trip"); // [RULE_03]

  property p_oc_needs_over;
    chan_ff[0] == CH_CONNECTED && !over_amps[0] && !sc_trip[0] |=> chan_ff[0] == CH_CONNECTED;
  endproperty
  a_oc_needs_over: assert property (p_oc_needs_over) else $error("early trip"); // [RULE_04]

  property p_load_open;
    chan_ff[0] != CH_CONNECTED |=> !load_switch_on;
  endproperty
  a_load_open: assert property (p_load_open) else $error("load left on"); // [RULE_02]

  property p_never_manual;
    outcfg_ff[1:0] == TRIG_NEVER && outcfg_ff[`OUT_POL0]
      |=> general_output_one == $past(outcfg_ff[`OUT_MAN0]);
  endproperty
  a_never_manual: assert property (p_never_manual) else $error("output moved"); // [RULE_10]

  property p_ot_hold;
    ot_ff && {1'b0, max_temp} + {1'b0, temp_ff[23:16]} >= {1'b0, temp_ff[7:0]} |=> ot_ff;
  endproperty
  a_ot_hold: assert property (p_ot_hold) else $error("over-temp cleared early"); // [RULE_13]

  property p_flag_query;
    rd_setup && paddr == `OFS_FLAG_QUERY |=> prdata == {24'h0, $past(flag_byte)};
  endproperty
  a_flag_query: assert property (p_flag_query) else $error("bad flag read"); // [RULE_19]

  property p_sync_high;
    pt_slot_ff == 2'd0 && pt_step_ff < `SYNC_STEPS |=> pulse_train_report;
  endproperty
  a_sync_high: assert property (p_sync_high) else $error("sync pulse low"); // [RULE_18]

  c_lock:  cover property (chan_ff[1] == CH_LOCKED ##1 fault_clear);
  c_retry: cover property (chan_ff[0] == CH_RETRY ##1 chan_ff[0] == CH_CONNECTED);
  c_gpo:   cover property (outcfg_ff[1:0] == TRIG_TEMP && ot_ff ##1 general_output_one);
endmodule
`default_nettype wire

// ===== test/bps_pack_model.sv
// far-side model: cells, sensors and host-reported conditions
// bench moves fields of m and c by nonblocking writes after a rising edge
`timescale 1ns/1ps
`default_nettype none

module bps_pack_model
(
  output var bps_pkg::meas_s meas,
  output var bps_pkg::cond_s cond
);
  import bps_pkg::*;
  meas_s m;
  cond_s c;
  assign meas = m;
  assign cond = c;
  // quiet pack so that no limit is violated out of reset
  initial
  begin
    m = '0;
    c = '0;
    m.max_cell_mv = 16'h0ed8;
    m.min_cell_mv = 16'h0e10;
    m.board_temp  = 8'h19;
  end
endmodule
`default_nettype wire

// ===== test/battery_protection_supervisor_tb_top.sv
// bench for the supervisor: apb master, pack model, one task per scenario
// assumes the zero-wait apb slave and shortened ms, medium and slow short, and step counts
`timescale 1ns/1ps
`default_nettype none
`include "bps_defines.svh"

module battery_protection_supervisor_tb_top;
  import bps_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  meas_s       meas;
  cond_s       cond;
  logic [3:0]  sw;
  logic [1:0]  go;
  logic        pulse;
  logic [5:0]  sn;
  int          num_errors = 0;
  int          tests_run = 0;
  localparam logic [7:0]  RA[10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
                                     8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
  localparam logic [31:0] RV[10] = '{`CTRL_RST, `SHORT_RST, `LEVEL_RST,
    `DELAY_RST, `LIMIT_RST, `IVAL_RST, `OUT_RST, `VOLT_RST, `TEMP_RST, 32'h0f00_0500};
  localparam int          SL[4] = '{125, 20, 50, 80};

  always #4 pclk = ~pclk;
  // settled copy of the pins, so checks never race the edge
  always @(negedge pclk) sn <= {go, sw};

  bps_pack_model pack (.meas(meas), .cond(cond));

  battery_protection_supervisor #(.MS_CYC(20), .SHORT_M_CYC(20),
    .SHORT_S_CYC(50), .TEMP_CYC(4), .STEP_CYC(1)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas(meas), .cond(cond), .pack_switch_on(sw[0]),
    .load_switch_on(sw[1]), .charge_switch_on(sw[2]), .brake_switch_on(sw[3]),
    .general_output_one(go[0]), .general_output_two(go[1]),
    .pulse_train_report(pulse));

  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", s, x, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk("prdata", x, q);
    chk("pslverr", xe, e);
  endtask

  task automatic wait_load(input logic v, input int lim);
    for (int n = 0; n < lim && sn[1] !== v; n++)
      @(posedge pclk);
    chk("load switch", v, sn[1]);
  endtask

  task automatic hi_run(output int n);
    n = 0;
    while (pulse !== 1'b0) @(negedge pclk);
    while (pulse !== 1'b1) @(negedge pclk);
    for (; pulse === 1'b1 && n < 300; n++)
      @(negedge pclk);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 10; i++)
      rd(RA[i], RV[i], 1'b0);
    chk("pins", 6'h0f, sn);
  endtask

  task automatic t_unmapped;
    logic [31:0] q;
    logic        e;
    apb(1'b1, 8'h38, 32'hffff_ffff, q, e);
    chk("write err", 1, e);
    rd(8'h38, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    rd(`OFS_CTRL, `CTRL_RST, 1'b0);
  endtask

  task automatic t_switch;
    for (int i = 0; i < 4; i++)
    begin
      wr(`OFS_CTRL, 32'h10 | (32'h1 << i));
      tick(2);
      chk("switches", 32'h1 << i, sn[3:0]);
    end
    wr(`OFS_CTRL, 32'h1f);
  endtask

  task automatic t_short;
    wr(`OFS_RETRY_IVAL, 32'h0002_0002);
    wr(`OFS_RETRY_LIMIT, 32'h0000_0101);
    for (int k = 0; k < 4; k++)
    begin
      wr(`OFS_SHORT_CFG, k);
      pack.m.short_seen <= 2'b01;
      tick(SL[k] / 2);
      chk("short early", 1, sn[1]);
      tick(SL[k] / 2 + 8);
      chk("short late", k == 3, sn[1]);
      if (k < 3)
        rd(`OFS_FLAG_QUERY, 32'h2, 1'b0);
      pack.m.short_seen <= 2'b00;
      wr(`OFS_CTRL, 32'h3f);
      wait_load(1'b1, 80);
    end
  endtask

  task automatic t_oc;
    // one retry left on the load channel, after the one that t_short consumed
    wr(`OFS_RETRY_LIMIT, 32'h0000_0102);
    wr(`OFS_TRIP_DELAY, 32'h0004_0004);
    wr(`OFS_OUT_CFG, 32'h0000_0033);
    pack.m.load_amps <= 16'd101;
    tick(55);
    chk("held", 1, sn[1]);
    wait_load(1'b0, 60);
    tick(2);
    chk("tripped", 6'h1d, sn);
    wait_load(1'b1, 80);
    wait_load(1'b0, 120);
    tick(3);
    rd(`OFS_STATE_QUERY, 32'h11, 1'b0);
    rd(`OFS_FLAG_QUERY, 32'h01, 1'b0);
    pack.m.load_amps <= 16'd50;
    tick(100);
    chk("locked", 0, sn[1]);
    wr(`OFS_CTRL, 32'h3f);
    tick(2);
    chk("cleared", 6'h0f, sn);
    rd(`OFS_FLAG_QUERY, 32'h0, 1'b0);
    wr(`OFS_RETRY_LIMIT, 32'h0);
    pack.m.load_amps <= 16'd101;
    wait_load(1'b0, 120);
    rd(`OFS_STATE_QUERY, 32'h11, 1'b0);
    pack.m.load_amps <= 16'd50;
    wr(`OFS_CTRL, 32'h3f);
  endtask

  task automatic t_volt;
    wr(`OFS_OUT_CFG, 32'h0000_0018);
    tick(2);
    chk("low polarity", 6'h2f, sn);
    pack.m.max_cell_mv <= 16'h10cc;
    tick(3);
    chk("over volt", 6'h0b, sn);
    rd(`OFS_FLAG_QUERY, 32'h04, 1'b0);
    pack.m.max_cell_mv <= 16'h0ed8;
    tick(3);
    chk("volt ok", 6'h2f, sn);
  endtask

  task automatic t_temp;
    logic [7:0] t[3];
    logic [5:0] x[3];
    t = '{8'h3d, 8'h39, 8'h36};
    x = '{6'h18, 6'h18, 6'h0f};
    wr(`OFS_OUT_CFG, 32'h0000_0031);
    for (int i = 0; i < 3; i++)
    begin
      pack.m.board_temp <= t[i];
      tick(12);
      chk("temp", x[i], sn);
    end
    pack.m.ext_valid <= 3'b100;
    pack.m.ext_temp <= 24'h3d_0000;
    tick(4);
    chk("ext temp", 6'h18, sn);
    pack.m.ext_valid <= 3'b000;
    tick(4);
  endtask

  task automatic t_uv;
    wr(`OFS_OUT_CFG, 32'h0000_00f0);
    pack.m.min_cell_mv <= 16'h0b54;
    tick(3);
    chk("under volt", 6'h3d, sn);
    rd(`OFS_OUT_QUERY, 32'h3, 1'b0);
    rd(`OFS_FLAG_QUERY, 32'h08, 1'b0);
    pack.m.min_cell_mv <= 16'h0e10;
    tick(3);
  endtask

  task automatic t_query;
    int         n;
    logic [7:0] v[3];
    v = '{8'h5a, 8'hb0, 8'h2f};
    pack.c.health_error_flag <= 1'b1;
    pack.c.internal_fault <= 1'b1;
    pack.c.hard_fault <= 1'b1;
    pack.c.regenerating_state <= 1'b1;
    pack.m.soc <= 8'h5a;
    wr(`OFS_CTRL, 32'hdf);
    tick(2);
    rd(`OFS_SOC_QUERY, v[0], 1'b0);
    rd(`OFS_FLAG_QUERY, v[1], 1'b0);
    rd(`OFS_STATE_QUERY, v[2], 1'b0);
    n = 0;
    for (int k = 0; k < 6 && n != 257; k++)
      hi_run(n);
    for (int i = 0; i < 3; i++)
    begin
      hi_run(n);
      chk("pulse width", v[i] + 1, n);
    end
  endtask

  task automatic give_verdict;
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_unmapped();
    t_switch();
    t_short();
    t_oc();
    t_volt();
    t_temp();
    t_uv();
    // pulse check ends on a falling edge, so it runs last
    t_query();
    give_verdict();
  end
endmodule
`default_nettype wire
